// ### link_fault_pkg.sv
package link_fault_pkg;
    // ----------------------------------------
    // geometry
    // ----------------------------------------
    localparam int NL = 4;
    localparam int NS = 4;
    localparam int AW = 8;
    // ----------------------------------------
    // register byte offsets
    // ----------------------------------------
    localparam logic [AW-1:0] OFS_CTRL = 8'h00;
    localparam logic [AW-1:0] OFS_TYPE_SEL = 8'h04;
    localparam logic [AW-1:0] OFS_ROUTE = 8'h08;
    localparam logic [AW-1:0] OFS_EYE_THR = 8'h0c;
    localparam logic [AW-1:0] OFS_RESEND_LIMIT = 8'h10;
    localparam logic [AW-1:0] OFS_FLAGS = 8'h14;
    localparam logic [AW-1:0] OFS_DECODE_CNT = 8'h18;
    localparam logic [AW-1:0] OFS_IDLE_CNT = 8'h1c;
    localparam logic [AW-1:0] OFS_TALLY = 8'h20;
    localparam logic [AW-1:0] OFS_RESEND_CNT = 8'h24;
    localparam logic [AW-1:0] OFS_RESEND_HIT = 8'h28;
    // ----------------------------------------
    // control field positions
    // ----------------------------------------
    localparam int CTRL_LTHR_LSB = 0;
    localparam int CTRL_PTHR_LSB = 8;
    localparam int CTRL_PEXP_LSB = 16;
    localparam int CTRL_LBW_BIT = 20;
    // ----------------------------------------
    // flag / route-enable bit positions
    // ----------------------------------------
    localparam int F_DEC = 0;
    localparam int F_IDLE = 4;
    localparam int F_TALLY = 8;
    localparam int F_EYE = 12;
    localparam int F_LINE = 16;
    localparam int F_LOCK = 17;
    localparam int F_UNLOCK = 18;
    localparam int F_RTC = 19;
    localparam int F_RTL = 20;
    localparam int F_REP = 24;
    localparam int F_SUM = 31;
    localparam int F_ROUTED = 21;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [31:0] CTRL_RST = 32'h0000_0101;
    localparam logic [15:0] TYPE_SEL_RST = 16'hffff;
    localparam logic [31:0] ROUTE_RST = 32'h0000_0000;
    localparam logic [7:0] EYE_THR_RST = 8'h10;
    localparam logic [31:0] RESEND_LIMIT_RST = 32'h0808_0808;
    // ----------------------------------------
    // running disparity bounds
    // ----------------------------------------
    localparam logic signed [5:0] DISP_MIN = -6'sh03;
    localparam logic signed [5:0] DISP_MAX = 6'sh03;
endpackage : link_fault_pkg

// ### link_error_flag_aggregator.sv
// The register addresses and the AHB-Lite register port were decided locally.
`timescale 1ns/100ps
module link_error_flag_aggregator (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [link_fault_pkg::AW-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [link_fault_pkg::NL-1:0] disp_valid,
    input wire logic [link_fault_pkg::NL-1:0][5:0] disp_level,
    input wire logic [link_fault_pkg::NL-1:0] idle_valid,
    input wire logic [link_fault_pkg::NL-1:0] idle_header,
    input wire logic [link_fault_pkg::NL-1:0][17:0] idle_word,
    input wire logic [link_fault_pkg::NL-1:0] pkt_valid,
    input wire logic [link_fault_pkg::NL-1:0][3:0] pkt_type,
    input wire logic [link_fault_pkg::NL-1:0] pkt_lowbw,
    input wire logic [link_fault_pkg::NL-1:0] eye_done,
    input wire logic [link_fault_pkg::NL-1:0][7:0] eye_value,
    input wire logic auto_err_clear,
    input wire logic auto_tally_clear,
    input wire logic [link_fault_pkg::NS-1:0] resend_pulse,
    input wire logic [link_fault_pkg::NS-1:0] ack_pulse,
    input wire logic [link_fault_pkg::NL-1:0] link_locked,
    input wire logic [3:0] line_fault_cond,
    output logic error_out_n,
    output logic error_out_oe
);
    import link_fault_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [NL-1:0] lock_m;
        logic [NL-1:0] lock_s;
        logic [NL-1:0] lock_p;
        logic [3:0] lf_m;
        logic [3:0] lf_s;
        logic [NL-1:0][7:0] dec_cnt;
        logic [NL-1:0][7:0] idle_cnt;
        logic [NL-1:0][7:0] tally;
        logic [NL-1:0][15:0] pre;
        logic [NL-1:0] eye_flag;
        logic [NL-1:0] eye_below;
        logic unlock_flag;
        logic [NS-1:0][6:0] resend_tally;
        logic [NS-1:0][7:0] rt_try;
        logic [NS-1:0] rt_hit;
        logic [31:0] ctrl;
        logic [15:0] tsel;
        logic [31:0] route;
        logic [7:0] eye_thr;
        logic [31:0] rlim;
        logic wr_pend;
        logic rd_pend;
        logic [AW-1:0] addr;
        logic hreadyout;
        logic [31:0] hrdata;
        logic error_out_n;
        logic error_out_oe;
    } state_s;

    state_s s_r;
    state_s s_nxt;

    logic [31:0] flags;
    logic [31:0] rdata;
    logic [15:0] pre_lim;
    logic [7:0] lthr;
    logic [7:0] pthr;
    logic [NL-1:0] relock;
    logic [NL-1:0] below;
    logic rd_now;
    logic clr_dec;
    logic clr_idle;
    logic clr_tally;
    logic clr_flags;
    logic clr_rtc;
    logic clr_hit;
    logic err;

    // ----------------------------------------
    // flag vector
    // ----------------------------------------
    always_comb begin
        lthr = s_r.ctrl[CTRL_LTHR_LSB +: 8];
        pthr = s_r.ctrl[CTRL_PTHR_LSB +: 8];
        flags = '0;
        for (int i = 0; i < NL; i++) begin
            flags[F_DEC + i] = s_r.dec_cnt[i] >= lthr;
            flags[F_IDLE + i] = s_r.idle_cnt[i] >= lthr;
            flags[F_TALLY + i] = s_r.tally[i] >= pthr;
            flags[F_EYE + i] = s_r.eye_flag[i];
        end
        flags[F_LINE] = |s_r.lf_s;
        flags[F_LOCK] = ~&s_r.lock_s;
        flags[F_UNLOCK] = s_r.unlock_flag;
        for (int k = 0; k < NS; k++) begin
            flags[F_RTC] = flags[F_RTC] | (s_r.route[F_REP + k] & (s_r.resend_tally[k] != 7'h00));
        end
        flags[F_RTL] = |s_r.rt_hit;
        flags[F_SUM] = ~s_r.error_out_n;
        err = |(flags[F_ROUTED-1:0] & s_r.route[F_ROUTED-1:0]);
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    always_comb begin
        rdata = '0;
        case (s_r.addr)
            OFS_CTRL: rdata = s_r.ctrl;
            OFS_TYPE_SEL: rdata[15:0] = s_r.tsel;
            OFS_ROUTE: rdata = s_r.route;
            OFS_EYE_THR: rdata[7:0] = s_r.eye_thr;
            OFS_RESEND_LIMIT: rdata = s_r.rlim;
            OFS_FLAGS: rdata = flags;
            OFS_DECODE_CNT: rdata = s_r.dec_cnt;
            OFS_IDLE_CNT: rdata = s_r.idle_cnt;
            OFS_TALLY: rdata = s_r.tally;
            OFS_RESEND_CNT: begin
                for (int k = 0; k < NS; k++) begin
                    rdata[8*k +: 7] = s_r.resend_tally[k];
                end
            end
            OFS_RESEND_HIT: rdata[NS-1:0] = s_r.rt_hit;
            default: rdata = '0;
        endcase
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        s_nxt = s_r;
        // level inputs from analog detectors are asynchronous
        s_nxt.lock_m = link_locked;
        s_nxt.lock_s = s_r.lock_m;
        s_nxt.lock_p = s_r.lock_s;
        s_nxt.lf_m = line_fault_cond;
        s_nxt.lf_s = s_r.lf_m;
        relock = s_r.lock_s & ~s_r.lock_p;

        // bus: reads take one wait state so a preceding write is seen
        rd_now = s_r.rd_pend;
        clr_dec = rd_now && s_r.addr == OFS_DECODE_CNT;
        clr_idle = rd_now && s_r.addr == OFS_IDLE_CNT;
        clr_tally = rd_now && s_r.addr == OFS_TALLY;
        clr_flags = rd_now && s_r.addr == OFS_FLAGS;
        clr_rtc = rd_now && s_r.addr == OFS_RESEND_CNT;
        clr_hit = rd_now && s_r.addr == OFS_RESEND_HIT;
        s_nxt.hreadyout = 1'b1;
        if (rd_now) begin
            s_nxt.hrdata = rdata;
            s_nxt.rd_pend = 1'b0;
        end
        if (s_r.wr_pend) begin
            s_nxt.wr_pend = 1'b0;
            case (s_r.addr)
                OFS_CTRL: s_nxt.ctrl = hwdata;
                OFS_TYPE_SEL: s_nxt.tsel = hwdata[15:0];
                OFS_ROUTE: s_nxt.route = hwdata;
                OFS_EYE_THR: s_nxt.eye_thr = hwdata[7:0];
                OFS_RESEND_LIMIT: s_nxt.rlim = hwdata;
                default: s_nxt.route = s_r.route;
            endcase
        end
        if (hready && hsel && htrans[1]) begin
            s_nxt.addr = {haddr[AW-1:2], 2'b00};
            s_nxt.wr_pend = hwrite;
            s_nxt.rd_pend = ~hwrite;
            s_nxt.hreadyout = hwrite;
        end

        // per-link counters; an event in a clearing cycle leaves a count of one
        pre_lim = 16'((17'h0_0001 << s_r.ctrl[CTRL_PEXP_LSB +: 4]) - 17'h0_0001);
        for (int i = 0; i < NL; i++) begin
            logic dec_ev;
            logic idle_ev;
            logic pkt_sel;
            logic step;
            dec_ev = disp_valid[i] && ($signed(disp_level[i]) > DISP_MAX
                || $signed(disp_level[i]) < DISP_MIN);
            idle_ev = idle_valid[i] && !idle_header[i] && (idle_word[i] != 18'h0_0000);
            pkt_sel = pkt_valid[i] && s_r.tsel[pkt_type[i]]
                && (pkt_lowbw[i] == s_r.ctrl[CTRL_LBW_BIT]);
            step = 1'b0;
            if (pkt_sel) begin
                if (s_r.pre[i] >= pre_lim) begin
                    s_nxt.pre[i] = '0;
                    step = 1'b1;
                end else begin
                    s_nxt.pre[i] = s_r.pre[i] + 16'h0001;
                end
            end
            if (clr_dec || auto_err_clear || relock[i]) begin
                s_nxt.dec_cnt[i] = {7'h00, dec_ev};
            end else if (dec_ev && s_r.dec_cnt[i] != 8'hff) begin
                s_nxt.dec_cnt[i] = s_r.dec_cnt[i] + 8'h01;
            end
            if (clr_idle || auto_err_clear || relock[i]) begin
                s_nxt.idle_cnt[i] = {7'h00, idle_ev};
            end else if (idle_ev && s_r.idle_cnt[i] != 8'hff) begin
                s_nxt.idle_cnt[i] = s_r.idle_cnt[i] + 8'h01;
            end
            if (clr_tally || auto_tally_clear) begin
                s_nxt.tally[i] = {7'h00, step};
                if (!pkt_sel) begin
                    s_nxt.pre[i] = '0;
                end
            end else if (step && s_r.tally[i] != 8'hff) begin
                s_nxt.tally[i] = s_r.tally[i] + 8'h01;
            end
            // eye monitor: the flag holds while the latest result is still low
            below[i] = eye_value[i] < s_r.eye_thr;
            if (eye_done[i]) begin
                s_nxt.eye_below[i] = below[i];
            end
            if (eye_done[i] && below[i]) begin
                s_nxt.eye_flag[i] = 1'b1;
            end else if (clr_flags && !s_r.eye_below[i]) begin
                s_nxt.eye_flag[i] = 1'b0;
            end
        end

        // loss of lock latch, set wins over read clear
        if (|(s_r.lock_p & ~s_r.lock_s)) begin
            s_nxt.unlock_flag = 1'b1;
        end else if (clr_flags) begin
            s_nxt.unlock_flag = 1'b0;
        end

        // sub-channel resends
        for (int k = 0; k < NS; k++) begin
            logic [7:0] lim;
            logic [7:0] tries;
            lim = s_r.rlim[8*k +: 8];
            tries = s_r.rt_try[k];
            if (ack_pulse[k]) begin
                tries = 8'h00;
            end else if (resend_pulse[k] && tries != 8'hff) begin
                tries = tries + 8'h01;
            end
            s_nxt.rt_try[k] = tries;
            if (clr_rtc) begin
                s_nxt.resend_tally[k] = {6'h00, resend_pulse[k]};
            end else if (resend_pulse[k] && s_r.resend_tally[k] != 7'h7f) begin
                s_nxt.resend_tally[k] = s_r.resend_tally[k] + 7'h01;
            end
            if (resend_pulse[k] && !ack_pulse[k] && lim != 8'h00 && tries >= lim) begin
                s_nxt.rt_hit[k] = 1'b1;
            end else if (clr_hit) begin
                s_nxt.rt_hit[k] = 1'b0;
            end
        end

        // ----------------------------------------
        // error pin, open drain: only ever pulled low
        // ----------------------------------------
        s_nxt.error_out_n = ~err;
        s_nxt.error_out_oe = err;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
            s_r.ctrl <= CTRL_RST;
            s_r.tsel <= TYPE_SEL_RST;
            s_r.route <= ROUTE_RST;
            s_r.eye_thr <= EYE_THR_RST;
            s_r.rlim <= RESEND_LIMIT_RST;
            s_r.hreadyout <= 1'b1;
            s_r.error_out_n <= 1'b1;
            s_r.lock_m <= '1;
            s_r.lock_s <= '1;
            s_r.lock_p <= '1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign hreadyout = s_r.hreadyout;
    assign hrdata = s_r.hrdata;
    assign hresp = 1'b0;
    assign error_out_n = s_r.error_out_n;
    assign error_out_oe = s_r.error_out_oe;

endmodule : link_error_flag_aggregator

// ### link_fault_chk.sv
`timescale 1ns/100ps
module link_fault_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic error_out_n,
    input wire logic error_out_oe
);
    logic rd_acc;
    logic wr_acc;
    logic wrote_r;
    assign rd_acc = hsel && hready && htrans[1] && !hwrite;
    assign wr_acc = hsel && hready && htrans[1] && hwrite;
    // nothing is routed until software has written once
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            wrote_r <= 1'b0;
        else if (wr_acc)
            wrote_r <= 1'b1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // bus and pin relations
    // ----------------------------------------
    a_read_wait: assert property (rd_acc |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_nowait: assert property (wr_acc |=> hreadyout)
        else $error("write stalled");
    a_single_wait: assert property (!hreadyout |=> hreadyout)
        else $error("wait state too long");
    a_wait_cause: assert property ($fell(hreadyout) |-> $past(rd_acc))
        else $error("wait state without read");
    a_data_hold: assert property ($changed(hrdata) |-> $past(!hreadyout))
        else $error("read data moved outside a read");
    a_resp_okay: assert property (!hresp)
        else $error("response not okay");
    a_oe_pin: assert property (error_out_oe == !error_out_n)
        else $error("pin enable disagrees with pin");
    a_pin_quiet: assert property (!wrote_r |-> error_out_n)
        else $error("pin active with nothing routed");
    c_read: cover property (rd_acc);
    c_write: cover property (wr_acc);
    c_pin: cover property ($fell(error_out_n));
endmodule : link_fault_chk

bind link_error_flag_aggregator link_fault_chk u_chk (.clk(clk), .rst(rst), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .error_out_n(error_out_n), .error_out_oe(error_out_oe));

// ### link_fault_host.sv
`timescale 1ns/100ps
module link_fault_host (
    input wire logic clk,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [7:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    output logic hready
);
    assign hready = hreadyout;
    initial begin
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
    end
    // one single word transfer; caller enters just after a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h0000_0000, q);
    endtask : rd
endmodule : link_fault_host

// ### testbench.sv
`timescale 1ns/100ps
module testbench;
    import link_fault_pkg::*;
    logic clk, rst, hsel, hwrite, hready, hreadyout, hresp, error_out_n, error_out_oe;
    logic auto_err_clear, auto_tally_clear;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata;
    logic [NL-1:0] disp_valid, idle_valid, idle_header, pkt_valid, pkt_lowbw, eye_done, link_locked;
    logic [NL-1:0][5:0] disp_level;
    logic [NL-1:0][17:0] idle_word;
    logic [NL-1:0][3:0] pkt_type;
    logic [NL-1:0][7:0] eye_value;
    logic [NS-1:0] resend_pulse, ack_pulse;
    logic [3:0] line_fault_cond;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;
    link_error_flag_aggregator u_link_error_flag_aggregator (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .disp_valid(disp_valid),
        .disp_level(disp_level), .idle_valid(idle_valid), .idle_header(idle_header), .idle_word(idle_word),
        .pkt_valid(pkt_valid), .pkt_type(pkt_type), .pkt_lowbw(pkt_lowbw), .eye_done(eye_done),
        .eye_value(eye_value), .auto_err_clear(auto_err_clear), .auto_tally_clear(auto_tally_clear),
        .resend_pulse(resend_pulse), .ack_pulse(ack_pulse), .link_locked(link_locked),
        .line_fault_cond(line_fault_cond), .error_out_n(error_out_n), .error_out_oe(error_out_oe));
    link_fault_host u_host (.clk(clk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic rx(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        u_host.rd(a, q);
        chk($sformatf("reg_%h", a), q, e);
    endtask : rx
    task automatic pin(input logic e);
        chk("error_out_n", {31'd0, error_out_n}, {31'd0, e});
    endtask : pin
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask : step
    task wrap_up;
        if (miscompares == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        rx(OFS_CTRL, 32'h0000_0101);
        rx(OFS_TYPE_SEL, 32'h0000_ffff);
        rx(OFS_ROUTE, 32'h0000_0000);
        rx(OFS_EYE_THR, 32'h0000_0010);
        rx(OFS_RESEND_LIMIT, 32'h0808_0808);
        u_host.wr(OFS_FLAGS, 32'hffff_ffff);
        u_host.wr(8'h30, 32'hffff_ffff);
        rx(OFS_FLAGS, 32'h0000_0000);
        rx(8'h30, 32'h0000_0000);
        pin(1'b1);
    endtask : t_reset
    task automatic t_decode();
        u_host.wr(OFS_ROUTE, 32'h0000_0001);
        disp_level <= {6'h00, 6'h3c, 6'h03, 6'h04};
        disp_valid <= 4'b0111;
        step(1);
        disp_valid <= 4'b0000;
        step(3);
        pin(1'b0);
        rx(OFS_FLAGS, 32'h8000_0005);
        rx(OFS_DECODE_CNT, 32'h0001_0001);
        rx(OFS_DECODE_CNT, 32'h0000_0000);
        step(3);
        pin(1'b1);
        disp_valid <= 4'b0001;
        step(300);
        disp_valid <= 4'b0000;
        step(2);
        rx(OFS_DECODE_CNT, 32'h0000_00ff);
        u_host.wr(OFS_ROUTE, 32'h0000_0000);
    endtask : t_decode
    task automatic t_idle();
        idle_word <= {18'h0, 18'h0, 18'h2_0000, 18'h0_0001};
        idle_header <= 4'b0001;
        idle_valid <= 4'b1011;
        step(1);
        idle_valid <= 4'b0000;
        step(2);
        rx(OFS_IDLE_CNT, 32'h0000_0100);
        idle_valid <= 4'b0010;
        step(1);
        idle_valid <= 4'b0000;
        step(2);
        rx(OFS_FLAGS, 32'h0000_0020);
        auto_err_clear <= 1'b1;
        step(1);
        auto_err_clear <= 1'b0;
        step(2);
        rx(OFS_FLAGS, 32'h0000_0000);
    endtask : t_idle
    task automatic t_tally();
        u_host.wr(OFS_CTRL, 32'h0002_0101);
        pkt_valid <= 4'b0001;
        step(3);
        pkt_lowbw <= 4'b0001;
        step(1);
        pkt_valid <= 4'b0000;
        pkt_lowbw <= 4'b0000;
        step(2);
        rx(OFS_FLAGS, 32'h0000_0000);
        pkt_valid <= 4'b0001;
        step(1);
        pkt_valid <= 4'b0000;
        step(2);
        rx(OFS_FLAGS, 32'h0000_0100);
        rx(OFS_TALLY, 32'h0000_0001);
        pkt_valid <= 4'b0001;
        step(4);
        pkt_valid <= 4'b0000;
        auto_tally_clear <= 1'b1;
        step(1);
        auto_tally_clear <= 1'b0;
        step(2);
        rx(OFS_FLAGS, 32'h0000_0000);
        u_host.wr(OFS_TYPE_SEL, 32'h0000_fffe);
        pkt_valid <= 4'b0001;
        step(4);
        pkt_valid <= 4'b0000;
        step(2);
        rx(OFS_TALLY, 32'h0000_0000);
        u_host.wr(OFS_TYPE_SEL, 32'h0000_ffff);
        u_host.wr(OFS_CTRL, 32'h0000_0101);
    endtask : t_tally
    task automatic t_eye(input logic [7:0] v, input logic [31:0] e1, input logic [31:0] e2);
        eye_value <= {24'h0, v};
        eye_done <= 4'b0001;
        step(1);
        eye_done <= 4'b0000;
        step(2);
        rx(OFS_FLAGS, e1);
        rx(OFS_FLAGS, e2);
    endtask : t_eye
    task automatic t_lock_line();
        u_host.wr(OFS_ROUTE, 32'h0002_0000);
        disp_valid <= 4'b0001;
        step(1);
        disp_valid <= 4'b0000;
        link_locked <= 4'b1110;
        step(6);
        pin(1'b0);
        link_locked <= 4'b1111;
        step(6);
        pin(1'b1);
        rx(OFS_FLAGS, 32'h0004_0000);
        rx(OFS_FLAGS, 32'h0000_0000);
        line_fault_cond <= 4'b0100;
        step(6);
        rx(OFS_FLAGS, 32'h0001_0000);
        rx(OFS_FLAGS, 32'h0001_0000);
        line_fault_cond <= 4'b0000;
        step(6);
        rx(OFS_FLAGS, 32'h0000_0000);
    endtask : t_lock_line
    task automatic t_resend();
        u_host.wr(OFS_RESEND_LIMIT, 32'h0000_0100);
        u_host.wr(OFS_ROUTE, 32'h0100_0000);
        resend_pulse <= 4'b0011;
        step(1);
        resend_pulse <= 4'b0010;
        step(2);
        resend_pulse <= 4'b0000;
        step(2);
        rx(OFS_FLAGS, 32'h0018_0000);
        rx(OFS_RESEND_HIT, 32'h0000_0002);
        rx(OFS_RESEND_HIT, 32'h0000_0000);
        rx(OFS_RESEND_CNT, 32'h0000_0301);
        resend_pulse <= 4'b0010;
        ack_pulse <= 4'b0010;
        step(1);
        resend_pulse <= 4'b0000;
        ack_pulse <= 4'b0000;
        step(2);
        rx(OFS_FLAGS, 32'h0000_0000);
        rx(OFS_RESEND_CNT, 32'h0000_0100);
    endtask : t_resend
    // ----------------------------------------
    // clock, timeout, main sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            wrap_up();
        end
    end
    initial begin
        rst = 1'b1;
        {disp_valid, idle_valid, idle_header, pkt_valid, pkt_lowbw, eye_done} = '0;
        {disp_level, idle_word, pkt_type, eye_value} = '0;
        {auto_err_clear, auto_tally_clear, resend_pulse, ack_pulse, line_fault_cond} = '0;
        link_locked = 4'b1111;
        step(2);
        rst <= 1'b0;
        step(1);
        t_reset();
        t_decode();
        t_idle();
        t_tally();
        t_eye(8'h0f, 32'h0000_1000, 32'h0000_1000);
        t_eye(8'h10, 32'h0000_1000, 32'h0000_0000);
        t_lock_line();
        t_resend();
        wrap_up();
    end
endmodule : testbench
